// >>> src_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********************
// reset receivers
// ********************
// counts each fresh initialization seen by the cpu core and peripherals
module src_periph_model (
   input wire logic aclk,
   input wire logic full_hardware_group_rst,
   input wire logic pin_power_group_rst,
   output var int full_inits,
   output var int pin_inits
);
   logic full_prev_reg;
   logic pin_prev_reg;
   always @(posedge aclk) begin
      full_prev_reg <= full_hardware_group_rst;
      pin_prev_reg <= pin_power_group_rst;
      if (full_hardware_group_rst === 1'b1 && full_prev_reg === 1'b0) begin
         full_inits <= full_inits + 1;
      end
      if (pin_power_group_rst === 1'b1 && pin_prev_reg === 1'b0) begin
         pin_inits <= pin_inits + 1;
      end
   end
endmodule
`default_nettype wire

// >>> src_pkg.sv
package src_pkg;
   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] KEY_SEL_OFF = 8'h04;
   localparam logic [7:0] SOFT_INIT_OFF = 8'h08;
   localparam logic [7:0] MOD_EN_OFF = 8'h0C;
   localparam logic [7:0] CAUSE_OFF = 8'h10;
   localparam logic [7:0] STATE_OFF = 8'h14;
   localparam int ADDR_W = 8;

   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int CTRL_KEY_EN_BIT = 0;
   localparam int CTRL_WDT_RST_BIT = 1;
   localparam int CTRL_VDET_RST_BIT = 2;
   localparam int CTRL_W = 3;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam int NUM_KEY = 8;
   localparam logic [7:0] KEY_SEL_RST = 8'h00;
   localparam int NUM_PERIPH = 8;
   localparam logic [7:0] SOFT_INIT_RST = 8'h00;
   localparam logic [7:0] MOD_EN_RST = 8'h00;
   // peripherals whose enable bit also initializes them
   localparam logic [7:0] MOD_EN_INIT_MASK = 8'h0F;
   localparam int CAUSE_PIN_BIT = 0;
   localparam int CAUSE_POR_BIT = 1;
   localparam int CAUSE_KEY_BIT = 2;
   localparam int CAUSE_WDT_BIT = 3;
   localparam int CAUSE_VDET_BIT = 4;
   localparam int CAUSE_W = 5;
   localparam logic [4:0] CAUSE_RST = 5'h00;
   localparam int STATE_FULL_BIT = 0;
   localparam int STATE_PIN_BIT = 1;
   localparam int STATE_SOFT_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int RESET_HOLD_TIME_NS = 100000;
   localparam int RESET_HOLD_CYC = (RESET_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PIN_MIN_LOW_NS = 1000;
   localparam int PIN_MIN_LOW_CYC = (PIN_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int KEY_MIN_LOW_NS = 10000;
   localparam int KEY_MIN_LOW_CYC = (KEY_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_W = 12;
   localparam int HOLD_W = 16;
endpackage

// >>> src_reset_ctrl.sv
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module src_reset_ctrl #(
   parameter int HOLD_CYC = src_pkg::RESET_HOLD_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic aclk_en,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic reset_pin_n,
   input wire logic power_on_req,
   input wire logic [7:0] key_pin_n,
   input wire logic wdt_overflow,
   input wire logic vdet_low,
   input wire logic osc_stable,
   output logic full_hardware_group_rst,
   output logic pin_power_group_rst,
   output logic [7:0] soft_group_rst,
   output logic [7:0] module_enable_bit
);
   // ****************************************
   // input synchronisers
   // ****************************************
   localparam int SYNC_W = 12;
   localparam logic [11:0] SYNC_RST = 12'h9FF;
   logic [11:0] sync1_reg;
   logic [11:0] sync2_reg;
   wire [11:0] async_in = {osc_stable, vdet_low, power_on_req, key_pin_n, reset_pin_n};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= SYNC_RST;
         sync2_reg <= SYNC_RST;
      end else if (aclk_en) begin
         sync1_reg <= async_in;
         sync2_reg <= sync1_reg;
      end
   end

   wire pin_low_s = ~sync2_reg[0];
   wire [7:0] key_n_s = sync2_reg[8:1];
   wire por_s = sync2_reg[9];
   wire vdet_s = sync2_reg[10];
   wire osc_ok_s = sync2_reg[11];

   // ****************************************
   // register file
   // ****************************************
   logic [2:0] ctrl_reg;
   logic [7:0] key_sel_reg;
   logic [7:0] soft_init_reg;
   logic [7:0] mod_en_reg;
   logic [7:0] mod_prev_reg;
   logic [4:0] cause_reg;

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
      reg_hit = (addr[7:2] == off[7:2]);
   endfunction

   // ****************************************
   // axi4-lite slave
   // ****************************************
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;

   wire aw_take = s_axi_awvalid & awready_reg;
   wire w_take = s_axi_wvalid & wready_reg;
   wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire aw_held_next = (aw_held_reg | aw_take) & ~wr_fire;
   wire w_held_next = (w_held_reg | w_take) & ~wr_fire;
   wire bvalid_next = wr_fire | (bvalid_reg & ~s_axi_bready);
   wire ar_take = s_axi_arvalid & arready_reg;
   wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
   // only the low byte carries fields, so lane 0 gates every write
   wire wr_lo = wr_fire & w_strb_reg[0];
   wire wr_ctrl = wr_lo & reg_hit(aw_addr_reg, src_pkg::CTRL_OFF);
   wire wr_key = wr_lo & reg_hit(aw_addr_reg, src_pkg::KEY_SEL_OFF);
   wire wr_soft = wr_lo & reg_hit(aw_addr_reg, src_pkg::SOFT_INIT_OFF);
   wire wr_mod = wr_lo & reg_hit(aw_addr_reg, src_pkg::MOD_EN_OFF);
   wire wr_cause = wr_lo & reg_hit(aw_addr_reg, src_pkg::CAUSE_OFF);
   wire wr_mapped = reg_hit(aw_addr_reg, src_pkg::CTRL_OFF) | reg_hit(aw_addr_reg, src_pkg::KEY_SEL_OFF)
      | reg_hit(aw_addr_reg, src_pkg::SOFT_INIT_OFF) | reg_hit(aw_addr_reg, src_pkg::MOD_EN_OFF)
      | reg_hit(aw_addr_reg, src_pkg::CAUSE_OFF) | reg_hit(aw_addr_reg, src_pkg::STATE_OFF);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= src_pkg::RESP_OKAY;
      end else if (aclk_en) begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         if (aw_take) begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         awready_reg <= ~aw_held_next & ~bvalid_next;
         wready_reg <= ~w_held_next & ~bvalid_next;
         bvalid_reg <= bvalid_next;
         if (wr_fire) begin
            bresp_reg <= wr_mapped ? src_pkg::RESP_OKAY : src_pkg::RESP_SLVERR;
         end
      end
   end

   logic full_rst_reg;
   logic pin_rst_reg;
   logic [7:0] soft_rst_reg;
   wire [31:0] state_word = {16'h0000, soft_rst_reg, 6'h00, pin_rst_reg, full_rst_reg};
   wire rd_mapped = reg_hit(s_axi_araddr, src_pkg::CTRL_OFF) | reg_hit(s_axi_araddr, src_pkg::KEY_SEL_OFF)
      | reg_hit(s_axi_araddr, src_pkg::SOFT_INIT_OFF) | reg_hit(s_axi_araddr, src_pkg::MOD_EN_OFF)
      | reg_hit(s_axi_araddr, src_pkg::CAUSE_OFF) | reg_hit(s_axi_araddr, src_pkg::STATE_OFF);
   wire [31:0] rd_word =
      reg_hit(s_axi_araddr, src_pkg::CTRL_OFF) ? {29'h00000000, ctrl_reg} :
      reg_hit(s_axi_araddr, src_pkg::KEY_SEL_OFF) ? {24'h000000, key_sel_reg} :
      reg_hit(s_axi_araddr, src_pkg::SOFT_INIT_OFF) ? {24'h000000, soft_init_reg} :
      reg_hit(s_axi_araddr, src_pkg::MOD_EN_OFF) ? {24'h000000, mod_en_reg} :
      reg_hit(s_axi_araddr, src_pkg::CAUSE_OFF) ? {27'h0000000, cause_reg} :
      reg_hit(s_axi_araddr, src_pkg::STATE_OFF) ? state_word : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= src_pkg::RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else if (aclk_en) begin
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         if (ar_take) begin
            rdata_reg <= rd_word;
            rresp_reg <= rd_mapped ? src_pkg::RESP_OKAY : src_pkg::RESP_SLVERR;
         end
      end
   end

   // ****************************************
   // reset sources
   // ****************************************
   // filter 0 is the reset pin, filter 1 the key-entry pins
   logic [11:0] filt_cnt_reg [2];
   wire key_all_low = (key_sel_reg != 8'h00) & (&(~key_sel_reg | ~key_n_s));
   wire [1:0] filt_low = {ctrl_reg[src_pkg::CTRL_KEY_EN_BIT] & key_all_low, pin_low_s};
   wire [11:0] filt_lim [2];
   assign filt_lim[0] = 12'(src_pkg::PIN_MIN_LOW_CYC);
   assign filt_lim[1] = 12'(src_pkg::KEY_MIN_LOW_CYC);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_filt
         // one high sample restarts the count, so a glitch never qualifies
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               filt_cnt_reg[gi] <= 12'h000;
            end else if (aclk_en) begin
               if (!filt_low[gi]) begin
                  filt_cnt_reg[gi] <= 12'h000;
               end else if (filt_cnt_reg[gi] != filt_lim[gi]) begin
                  filt_cnt_reg[gi] <= filt_cnt_reg[gi] + 12'h001;
               end
            end
         end
      end
   endgenerate

   wire pin_req = filt_low[0] & (filt_cnt_reg[0] == filt_lim[0]);
   wire key_req = filt_low[1] & (filt_cnt_reg[1] == filt_lim[1]);
   wire por_req = por_s;
   wire wdt_req = ctrl_reg[src_pkg::CTRL_WDT_RST_BIT] & wdt_overflow;
   wire vdet_req = ctrl_reg[src_pkg::CTRL_VDET_RST_BIT] & vdet_s;
   wire [4:0] cause_set = {vdet_req, wdt_req, key_req, por_req, pin_req};

   // ****************************************
   // hardware groups with hold
   // ****************************************
   wire [1:0] hold_act;
   assign hold_act[0] = pin_req | por_req | key_req | vdet_req | wdt_req | ~osc_ok_s;
   assign hold_act[1] = pin_req | por_req | ~osc_ok_s;
   logic [15:0] hold_cnt_reg [2];
   logic [1:0] grp_rst_reg;

   generate
      for (gi = 0; gi < 2; gi++) begin : g_hold
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               hold_cnt_reg[gi] <= 16'(HOLD_CYC);
               grp_rst_reg[gi] <= 1'b1;
            end else if (aclk_en) begin
               if (hold_act[gi]) begin
                  hold_cnt_reg[gi] <= 16'(HOLD_CYC);
               end else if (hold_cnt_reg[gi] != 16'h0000) begin
                  hold_cnt_reg[gi] <= hold_cnt_reg[gi] - 16'h0001;
               end
               grp_rst_reg[gi] <= hold_act[gi] | (hold_cnt_reg[gi] > 16'h0001);
            end
         end
      end
   endgenerate

   // ****************************************
   // registers, cause flags and soft group
   // ****************************************
   wire [7:0] mod_rise = mod_en_reg & ~mod_prev_reg & src_pkg::MOD_EN_INIT_MASK;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= src_pkg::CTRL_RST;
         key_sel_reg <= src_pkg::KEY_SEL_RST;
         soft_init_reg <= src_pkg::SOFT_INIT_RST;
         mod_en_reg <= src_pkg::MOD_EN_RST;
         mod_prev_reg <= src_pkg::MOD_EN_RST;
         cause_reg <= src_pkg::CAUSE_RST;
         soft_rst_reg <= 8'h00;
      end else if (aclk_en) begin
         if (wr_ctrl) begin
            ctrl_reg <= w_data_reg[2:0];
         end
         if (wr_key) begin
            key_sel_reg <= w_data_reg[7:0];
         end
         if (wr_soft) begin
            soft_init_reg <= w_data_reg[7:0];
         end
         if (wr_mod) begin
            mod_en_reg <= w_data_reg[7:0];
         end
         mod_prev_reg <= mod_en_reg;
         // a new event beats a same-cycle write-one clear
         cause_reg <= cause_set | (cause_reg & ~({5{wr_cause}} & w_data_reg[4:0]));
         soft_rst_reg <= soft_init_reg | mod_rise;
      end
   end

   assign full_rst_reg = grp_rst_reg[0];
   assign pin_rst_reg = grp_rst_reg[1];
   assign full_hardware_group_rst = full_rst_reg;
   assign pin_power_group_rst = pin_rst_reg;
   assign soft_group_rst = soft_rst_reg;
   assign module_enable_bit = mod_en_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   // ****************************************
   // assertions
   // ****************************************
   sequence s_pin_qualified;
      pin_req && aclk_en;
   endsequence
   sequence s_full_drop;
      hold_act[0] && aclk_en ##1 !hold_act[0] && aclk_en;
   endsequence

   a_pin_request: assert property (@(posedge aclk) disable iff (!aresetn)
      s_pin_qualified |=> full_hardware_group_rst && pin_power_group_rst)
      else $error("pin request did not reset both hardware groups");
   a_pin_glitch_drop: assert property (@(posedge aclk) disable iff (!aresetn)
      (!pin_low_s && aclk_en) |=> !pin_req && filt_cnt_reg[0] == 12'h000)
      else $error("pin filter kept counting across a high sample");
   a_por_request: assert property (@(posedge aclk) disable iff (!aresetn)
      (por_s && aclk_en) |=> full_hardware_group_rst && pin_power_group_rst && cause_reg[1])
      else $error("power-on request not honoured");
   a_key_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      key_req |-> ctrl_reg[0] && $past(filt_low[1]))
      else $error("key reset raised while disabled");
   a_wdt_reset_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      (wdt_overflow && aclk_en) |=> full_hardware_group_rst == ($past(ctrl_reg[1]) || $past(hold_act[0])
      || $past(hold_cnt_reg[0]) > 16'h0001))
      else $error("watchdog overflow handled against its mode");
   a_vdet_request: assert property (@(posedge aclk) disable iff (!aresetn)
      (vdet_s && ctrl_reg[2] && aclk_en) |=> full_hardware_group_rst ##0 cause_reg[4])
      else $error("voltage drop did not reset full group");
   a_soft_init_bit: assert property (@(posedge aclk) disable iff (!aresetn)
      (soft_init_reg[0] && aclk_en) |=> soft_group_rst[0])
      else $error("soft init did not reset peripheral");
   a_pin_group_scope: assert property (@(posedge aclk) disable iff (!aresetn)
      (!pin_req && !por_s && osc_ok_s && hold_cnt_reg[1] == 16'h0000 && aclk_en) |=> !pin_power_group_rst)
      else $error("pin group reset by a foreign source");
   a_hold_after_drop: assert property (@(posedge aclk) disable iff (!aresetn)
      s_full_drop |=> full_hardware_group_rst && hold_cnt_reg[0] == 16'(HOLD_CYC - 1))
      else $error("full group left reset without hold");
   a_soft_release: assert property (@(posedge aclk) disable iff (!aresetn)
      (!soft_init_reg[0] && !mod_rise[0] && aclk_en) |=> !soft_group_rst[0])
      else $error("soft group release delayed");
   a_unstable_clock: assert property (@(posedge aclk) disable iff (!aresetn)
      (!osc_ok_s && aclk_en) |=> full_hardware_group_rst && pin_power_group_rst)
      else $error("groups released with unstable clock");
   a_release_at_end: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(full_hardware_group_rst) |-> $past(hold_cnt_reg[0]) == 16'h0001 && !$past(hold_act[0]))
      else $error("full group released before hold ended");
endmodule
`default_nettype wire

// >>> test_system_reset_controller.sv
`timescale 1ns/100ps
`default_nettype none
module test_system_reset_controller;
   // ********************
   // signals
   // ********************
   // short hold keeps the run brief; the hold window that rel checks follows from it
   localparam int HOLD = 20;
   logic aclk, aresetn, aclk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reset_pin_n, power_on_req;
   logic wdt_overflow, vdet_low, osc_stable, full_hardware_group_rst, pin_power_group_rst;
   logic [7:0] s_axi_awaddr, s_axi_araddr, key_pin_n, soft_group_rst, module_enable_bit;
   logic [31:0] s_axi_wdata, s_axi_rdata, data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int full_inits, pin_inits, num_errors, checks;
   src_reset_ctrl #(.HOLD_CYC(HOLD)) dut (.aclk, .aresetn, .aclk_en, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .reset_pin_n, .power_on_req, .key_pin_n, .wdt_overflow, .vdet_low, .osc_stable,
      .full_hardware_group_rst, .pin_power_group_rst, .soft_group_rst, .module_enable_bit);
   src_periph_model far_end (.aclk, .full_hardware_group_rst, .pin_power_group_rst, .full_inits, .pin_inits);
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // ********************
   // helpers
   // ********************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic grp(input string what, input logic f, input logic p);
      chk({what, " full"}, {31'h0, full_hardware_group_rst}, {31'h0, f});
      chk({what, " pin"}, {31'h0, pin_power_group_rst}, {31'h0, p});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit aw_ok;
      bit w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      // no cycle budget here: only the watchdog ends a stuck wait
      do begin
         @(posedge aclk);
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
      end while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (s_axi_rvalid !== 1'b1);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // counted from the request drop; input synchronisers need the slack
   task automatic rel(input string what);
      int n;
      n = 0;
      while (n < 3000 && full_hardware_group_rst !== 1'b0) begin
         @(posedge aclk);
         n++;
      end
      chk({what, " hold"}, {31'h0, (n >= HOLD && n <= HOLD + 8)}, 32'h1);
      chk({what, " pin free"}, {31'h0, pin_power_group_rst}, 32'h0);
   endtask
   task automatic drv(input int which, input logic on);
      case (which)
         0: reset_pin_n <= !on;
         1: power_on_req <= on;
         2: key_pin_n <= on ? 8'h7E : 8'hFF;
         3: wdt_overflow <= on;
         default: vdet_low <= on;
      endcase
   endtask
   // ********************
   // scenarios
   // ********************
   task automatic t_boot;
      grp("boot", 1'b1, 1'b1);
      chk("boot soft", {24'h0, soft_group_rst}, 32'h0);
      chk("boot enable", {24'h0, module_enable_bit}, 32'h0);
      rel("boot");
      for (int i = 0; i < 6; i++) begin
         rd(8'(4 * i));
         chk("reset value", data, 32'h0);
         chk("reset resp", {30'h0, resp}, {30'h0, src_pkg::RESP_OKAY});
      end
      rd(8'h18);
      chk("unmapped resp", {30'h0, resp}, {30'h0, src_pkg::RESP_SLVERR});
      chk("unmapped data", data, 32'h0);
      wr(8'h18, 32'h0);
      chk("unmapped wr resp", {30'h0, resp}, {30'h0, src_pkg::RESP_SLVERR});
      $display("test boot done");
   endtask
   task automatic t_src(input string what, input int which, input logic [31:0] ctrl, input logic pin_too,
         input int short_cyc, input int long_cyc);
      int f0;
      int p0;
      wr(src_pkg::CTRL_OFF, 32'h0);
      if (short_cyc > 0) begin
         drv(which, 1'b1);
         cyc(short_cyc);
         drv(which, 1'b0);
         cyc(10);
         grp({what, " refused"}, 1'b0, 1'b0);
      end
      wr(src_pkg::CAUSE_OFF, 32'h1F);
      f0 = full_inits;
      p0 = pin_inits;
      wr(src_pkg::CTRL_OFF, ctrl);
      chk({what, " write resp"}, {30'h0, resp}, {30'h0, src_pkg::RESP_OKAY});
      rd(src_pkg::CTRL_OFF);
      chk({what, " control"}, data, ctrl);
      drv(which, 1'b1);
      cyc(long_cyc);
      grp(what, 1'b1, pin_too);
      drv(which, 1'b0);
      rel(what);
      chk({what, " full inits"}, 32'(full_inits - f0), 32'h1);
      chk({what, " pin inits"}, 32'(pin_inits - p0), {31'h0, pin_too});
      rd(src_pkg::CAUSE_OFF);
      chk({what, " cause"}, data, 32'h1 << which);
      wr(src_pkg::CAUSE_OFF, 32'h1F);
      rd(src_pkg::CAUSE_OFF);
      chk({what, " cause clear"}, data, 32'h0);
      $display("test %s done", what);
   endtask
   task automatic t_soft;
      logic [7:0] seen;
      int width;
      seen = 8'h00;
      width = 0;
      wr(src_pkg::SOFT_INIT_OFF, 32'hA5);
      cyc(2);
      chk("soft level", {24'h0, soft_group_rst}, 32'hA5);
      grp("soft", 1'b0, 1'b0);
      rd(src_pkg::STATE_OFF);
      chk("soft state", data, 32'hA500);
      wr(src_pkg::SOFT_INIT_OFF, 32'h0);
      // output is registered, so it follows the clear one edge later
      cyc(1);
      chk("soft release", {24'h0, soft_group_rst}, 32'h0);
      fork
         wr(src_pkg::MOD_EN_OFF, 32'h81);
         for (int i = 0; i < 12; i++) begin
            @(posedge aclk);
            seen = seen | soft_group_rst;
            width += int'(soft_group_rst[0]);
         end
      join
      chk("enable bits", {24'h0, module_enable_bit}, 32'h81);
      chk("enable pulse", {24'h0, seen}, 32'h01);
      chk("pulse width", 32'(width), 32'h1);
      wr(src_pkg::MOD_EN_OFF, 32'h0);
      $display("test soft done");
   endtask
   // a frozen block must not see a request that comes and goes meanwhile
   task automatic t_freeze;
      aclk_en <= 1'b0;
      power_on_req <= 1'b1;
      cyc(8);
      power_on_req <= 1'b0;
      cyc(4);
      aclk_en <= 1'b1;
      cyc(4);
      grp("freeze", 1'b0, 1'b0);
      $display("test freeze done");
   endtask
   task automatic t_osc;
      osc_stable <= 1'b0;
      cyc(10);
      grp("osc", 1'b1, 1'b1);
      power_on_req <= 1'b1;
      cyc(8);
      power_on_req <= 1'b0;
      cyc(40);
      grp("osc last", 1'b1, 1'b1);
      osc_stable <= 1'b1;
      rel("osc");
      wr(src_pkg::CAUSE_OFF, 32'h1F);
      $display("test osc done");
   endtask
   // ********************
   // run control
   // ********************
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      $display("[FAIL] run length expected finish seen timeout");
      wrap_up();
   end
   initial begin
      aresetn = 1'b0;
      aclk_en = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {reset_pin_n, power_on_req, wdt_overflow, vdet_low, osc_stable} = 5'h11;
      key_pin_n = 8'hFF;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_boot();
      t_src("pin", 0, 32'h0, 1'b1, 100, 140);
      t_src("por", 1, 32'h0, 1'b1, 0, 8);
      wr(src_pkg::KEY_SEL_OFF, 32'h81);
      t_src("key", 2, 32'h1, 1'b0, 1300, 1300);
      t_src("wdt", 3, 32'h2, 1'b0, 4, 4);
      t_src("vdet", 4, 32'h4, 1'b0, 8, 8);
      t_soft();
      t_freeze();
      t_osc();
      wrap_up();
   end
endmodule
`default_nettype wire
